// ===== card_mon_pkg.sv
package card_mon_pkg;

	// ***************************************************************
	// bus and socket sizes
	// ***************************************************************
	localparam int NUM_SOCKETS = 2;
	localparam int EVENTS_PER_SOCKET = 4;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int SYNC_STAGES = 2;

	// ***************************************************************
	// register offsets
	// ***************************************************************
	localparam logic [ADDR_W-1:0] OFF_SOCK_A_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_SOCK_B_STATUS = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_MODE = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_CHANGE_STATUS = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_CHANGE_CLEAR = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_CHANGE_ENABLE = 4'h5;
	localparam logic [ADDR_W-1:0] OFF_INFO = 4'h6;

	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int ST_DETECT_FIRST = 0;
	localparam int ST_DETECT_SECOND = 1;
	localparam int ST_PRESENT = 2;
	localparam int ST_BATTERY_FIRST = 3;
	localparam int ST_BATTERY_SECOND = 4;
	localparam int ST_READY = 5;
	localparam int ST_PROTECT_OR_WIDE = 6;
	localparam int ST_WAIT = 7;

	localparam int EV_DETECT = 0;
	localparam int EV_BATTERY_FIRST = 1;
	localparam int EV_BATTERY_SECOND = 2;
	localparam int EV_READY = 3;

	localparam int INFO_STRAP = 0;
	localparam int INFO_PROTECTED = 1;
	localparam int INFO_WIDE = 3;
	localparam int INFO_BUSY = 5;

	// ***************************************************************
	// reset values
	// ***************************************************************
	localparam logic [NUM_SOCKETS-1:0] MODE_RESET = 2'h0;
	localparam logic [DATA_W-1:0] ENABLE_RESET = 8'h00;
	localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
	// pins are pulled up, so idle reads as all ones
	localparam logic [6:0] PINS_IDLE = 7'h7f;

	// ***************************************************************
	// carriers
	// ***************************************************************
	// battery_first is card_status_changed_n, battery_second is card_audio_n
	// and protect_or_wide is card_wide_io_n when the socket is in i/o mode
	typedef struct packed {
		logic detect_first;
		logic detect_second;
		logic battery_first;
		logic battery_second;
		logic wait_req_n;
		logic ready_busy;
		logic protect_or_wide;
	} sock_pins_s;

	typedef struct packed {
		logic              write;
		logic              read;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_s;

endpackage

// ===== status_sync.sv
`timescale 1ns/1ps
module status_sync #(
	parameter int         WIDTH       = 14,
	parameter logic [13:0] RESET_VALUE = 14'h3fff
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// levels
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	if (WIDTH < 1 || WIDTH > 14) begin : g_check
		$error("status_sync width out of range");
	end

	logic [WIDTH-1:0] meta_reg;

	// meta_reg feeds only the second stage
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= RESET_VALUE[WIDTH-1:0];
			sync_o   <= RESET_VALUE[WIDTH-1:0];
		end else begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end

endmodule // status_sync

// ===== sticky_flags.sv
`timescale 1ns/1ps
module sticky_flags #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// events and software control
	input  wire logic [WIDTH-1:0] set_i,
	input  wire logic [WIDTH-1:0] clear_i,
	input  wire logic [WIDTH-1:0] enable_i,
	// state
	output logic      [WIDTH-1:0] flags_o,
	output logic                  irq_o
);

	if (WIDTH < 1 || WIDTH > 8) begin : g_check
		$error("sticky_flags width out of range");
	end

	logic [WIDTH-1:0] flags_next;

	// set beats clear so a change landing on the clear is kept
	always_comb begin
		flags_next = (flags_o & ~clear_i) | set_i;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags_o <= '0;
		end else begin
			flags_o <= flags_next;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(flags_next & enable_i);
		end
	end

endmodule // sticky_flags

// ===== card_socket_status_monitor.sv
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// ***************************************************************
// Functional notes
// [R1] card detect pins are active low; card present only when both low
// [R2] raw card detect levels of each socket readable in status registers
// [R3] enabled card detect transition raises the host interrupt
// [R4] memory card: both battery detect levels shown in socket status
// [R5] battery detect change is an interrupt source when enabled
// [R6] i/o mode: first battery pin is active-low card status change
// [R7] status change level reported, its change can raise an interrupt
// [R8] i/o mode: second battery pin is active-low card audio
// [R9] card audio drives the speaker pin shared with base select strap
// [R10] card pulls wait low to stretch a cycle; wait passed to host
// [R11] memory mode: ready high means next cycle can be taken
// [R12] memory mode: ready low means card busy
// [R13] ready level mirrored in a status bit
// [R14] ready change is an interrupt source shown in status
// [R15] memory mode: protect pin high means write protected
// [R16] i/o mode: protect pin low requests 16-bit i/o width
// [R17] every socket pin passes two flip-flops before use
// [R18] changes set sticky flags until cleared; irq is or of enabled flags
// [R19] host 16-bit i/o indication asserted low during wide i/o access
// ***************************************************************
module card_socket_status_monitor (
	// clock and reset
	input  wire logic                              ref_clk_i,
	input  wire logic                              reset_n_i,
	// register port
	input  wire card_mon_pkg::reg_req_s            reg_req_i,
	output logic [card_mon_pkg::DATA_W-1:0]        reg_rdata_o,
	// socket pins
	input  wire card_mon_pkg::sock_pins_s          sock_a_pins_i,
	input  wire card_mon_pkg::sock_pins_s          sock_b_pins_i,
	input  wire logic [card_mon_pkg::NUM_SOCKETS-1:0] sock_access_i,
	// host interrupt
	output logic                                   irq_o,
	// host open-drain pins
	output logic                                   host_wait_req_n_o,
	output logic                                   host_wait_req_n_oe_o,
	output logic                                   host_wide_io_n_o,
	output logic                                   host_wide_io_n_oe_o,
	// speaker pin shared with base select strap
	input  wire logic                              base_select_zero_i,
	output logic                                   card_audio_n_o,
	output logic                                   card_audio_n_oe_o
);

	localparam int NS = card_mon_pkg::NUM_SOCKETS;
	localparam int PW = $bits(card_mon_pkg::sock_pins_s);
	localparam int NE = NS * card_mon_pkg::EVENTS_PER_SOCKET;
	localparam int DW = card_mon_pkg::DATA_W;

	// ***************************************************************
	// helpers
	// ***************************************************************
	function automatic logic card_present(input card_mon_pkg::sock_pins_s p);
		card_present = !p.detect_first && !p.detect_second; // see [R1]
	endfunction

	function automatic logic [DW-1:0] status_byte(input card_mon_pkg::sock_pins_s p);
		status_byte = '0;
		status_byte[card_mon_pkg::ST_DETECT_FIRST] = p.detect_first; // see [R2]
		status_byte[card_mon_pkg::ST_DETECT_SECOND] = p.detect_second; // see [R2]
		status_byte[card_mon_pkg::ST_PRESENT] = card_present(p); // see [R1]
		status_byte[card_mon_pkg::ST_BATTERY_FIRST] = p.battery_first; // see [R4] [R7]
		status_byte[card_mon_pkg::ST_BATTERY_SECOND] = p.battery_second; // see [R4]
		status_byte[card_mon_pkg::ST_READY] = p.ready_busy; // see [R13]
		status_byte[card_mon_pkg::ST_PROTECT_OR_WIDE] = p.protect_or_wide;
		status_byte[card_mon_pkg::ST_WAIT] = p.wait_req_n;
	endfunction

	// ***************************************************************
	// reset release
	// ***************************************************************
	logic [1:0] rst_sync_reg;
	logic       rst_n;

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_reg[1];

	// ***************************************************************
	// pin synchronisers
	// ***************************************************************
	logic [2*PW-1:0]             pins_flat;
	card_mon_pkg::sock_pins_s    pins_sync [NS];
	card_mon_pkg::sock_pins_s    pins_prev_reg [NS];

	status_sync #(
		.WIDTH       (2 * PW),
		.RESET_VALUE ({card_mon_pkg::PINS_IDLE, card_mon_pkg::PINS_IDLE})
	) u_sync (
		.clk_i   (ref_clk_i),
		.rst_n_i (rst_n),
		.async_i ({sock_b_pins_i, sock_a_pins_i}), // see [R17]
		.sync_o  (pins_flat)
	);

	assign pins_sync[0] = pins_flat[PW-1:0];
	assign pins_sync[1] = pins_flat[2*PW-1:PW];

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int s = 0; s < NS; s++) begin
				pins_prev_reg[s] <= card_mon_pkg::PINS_IDLE;
			end
		end else begin
			for (int s = 0; s < NS; s++) begin
				pins_prev_reg[s] <= pins_sync[s];
			end
		end
	end

	// ***************************************************************
	// software registers
	// ***************************************************************
	logic [NS-1:0] io_mode_reg;
	logic [DW-1:0] enable_reg;
	logic [NE-1:0] clear_mask;
	logic [NE-1:0] change_flags;

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			io_mode_reg <= card_mon_pkg::MODE_RESET;
		end else if (reg_req_i.write && reg_req_i.addr == card_mon_pkg::OFF_MODE) begin
			io_mode_reg <= reg_req_i.wdata[NS-1:0];
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg <= card_mon_pkg::ENABLE_RESET;
		end else if (reg_req_i.write && reg_req_i.addr == card_mon_pkg::OFF_CHANGE_ENABLE) begin
			enable_reg <= reg_req_i.wdata;
		end
	end

	always_comb begin
		clear_mask = '0;
		if (reg_req_i.write && reg_req_i.addr == card_mon_pkg::OFF_CHANGE_CLEAR) begin
			clear_mask = reg_req_i.wdata[NE-1:0];
		end
	end

	// ***************************************************************
	// change events
	// ***************************************************************
	logic [NE-1:0] events;

	always_comb begin
		events = '0;
		for (int s = 0; s < NS; s++) begin
			events[s*4 + card_mon_pkg::EV_DETECT] =
				(pins_sync[s].detect_first ^ pins_prev_reg[s].detect_first) |
				(pins_sync[s].detect_second ^ pins_prev_reg[s].detect_second); // see [R3]
			// in i/o mode this is the status change line
			events[s*4 + card_mon_pkg::EV_BATTERY_FIRST] =
				pins_sync[s].battery_first ^ pins_prev_reg[s].battery_first; // see [R5] [R6]
			// audio toggles constantly, so no event in i/o mode
			events[s*4 + card_mon_pkg::EV_BATTERY_SECOND] = !io_mode_reg[s] &&
				(pins_sync[s].battery_second ^ pins_prev_reg[s].battery_second); // see [R5]
			events[s*4 + card_mon_pkg::EV_READY] =
				pins_sync[s].ready_busy ^ pins_prev_reg[s].ready_busy; // see [R14]
		end
	end

	sticky_flags #(
		.WIDTH (NE)
	) u_flags (
		.clk_i    (ref_clk_i),
		.rst_n_i  (rst_n),
		.set_i    (events), // see [R18]
		.clear_i  (clear_mask),
		.enable_i (enable_reg[NE-1:0]),
		.flags_o  (change_flags),
		.irq_o    (irq_o) // see [R3] [R7]
	);

	// ***************************************************************
	// strap and speaker pin
	// ***************************************************************
	logic strap_taken_reg;
	logic strap_reg;
	logic audio_active;

	// pin is an input until the strap is caught after reset
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			strap_taken_reg <= 1'b0;
			strap_reg       <= 1'b0;
		end else if (!strap_taken_reg) begin
			strap_taken_reg <= 1'b1;
			strap_reg       <= base_select_zero_i;
		end
	end

	always_comb begin
		audio_active = 1'b0;
		for (int s = 0; s < NS; s++) begin
			audio_active = audio_active | (io_mode_reg[s] && !pins_sync[s].battery_second); // see [R8]
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			card_audio_n_o    <= 1'b1;
			card_audio_n_oe_o <= 1'b0;
		end else begin
			card_audio_n_o    <= !audio_active; // see [R9]
			card_audio_n_oe_o <= strap_taken_reg;
		end
	end

	// ***************************************************************
	// host wait and wide i/o
	// ***************************************************************
	logic [NS-1:0] wait_req;
	logic [NS-1:0] wide_req;

	always_comb begin
		for (int s = 0; s < NS; s++) begin
			wait_req[s] = sock_access_i[s] && !pins_sync[s].wait_req_n; // see [R10]
			wide_req[s] = io_mode_reg[s] && !pins_sync[s].protect_or_wide; // see [R16]
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			host_wait_req_n_o    <= 1'b0;
			host_wait_req_n_oe_o <= 1'b0;
		end else begin
			host_wait_req_n_o    <= 1'b0;
			host_wait_req_n_oe_o <= |wait_req; // see [R10]
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			host_wide_io_n_o    <= 1'b0;
			host_wide_io_n_oe_o <= 1'b0;
		end else begin
			host_wide_io_n_o    <= 1'b0;
			host_wide_io_n_oe_o <= |(wide_req & sock_access_i); // see [R19]
		end
	end

	// ***************************************************************
	// read path
	// ***************************************************************
	logic [DW-1:0] info;

	always_comb begin
		info = '0;
		info[card_mon_pkg::INFO_STRAP] = strap_reg;
		for (int s = 0; s < NS; s++) begin
			info[card_mon_pkg::INFO_PROTECTED + s] =
				!io_mode_reg[s] && pins_sync[s].protect_or_wide; // see [R15]
			info[card_mon_pkg::INFO_WIDE + s] = wide_req[s]; // see [R16]
			info[card_mon_pkg::INFO_BUSY + s] =
				!io_mode_reg[s] && !pins_sync[s].ready_busy; // see [R11] [R12]
		end
	end

	// data stand only in the cycle after the read
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_o <= '0;
		end else if (!reg_req_i.read) begin
			reg_rdata_o <= '0;
		end else begin
			unique case (reg_req_i.addr)
				card_mon_pkg::OFF_SOCK_A_STATUS: reg_rdata_o <= status_byte(pins_sync[0]);
				card_mon_pkg::OFF_SOCK_B_STATUS: reg_rdata_o <= status_byte(pins_sync[1]);
				card_mon_pkg::OFF_MODE:          reg_rdata_o <= {{(DW-NS){1'b0}}, io_mode_reg};
				card_mon_pkg::OFF_CHANGE_STATUS: reg_rdata_o <= change_flags; // see [R14]
				card_mon_pkg::OFF_CHANGE_ENABLE: reg_rdata_o <= enable_reg;
				card_mon_pkg::OFF_INFO:          reg_rdata_o <= info;
				default:                         reg_rdata_o <= '0;
			endcase
		end
	end

	// ***************************************************************
	// assertions
	// ***************************************************************
	// socket b ready flag, the one the bench lands a clear on
	localparam int B_READY = card_mon_pkg::EVENTS_PER_SOCKET + card_mon_pkg::EV_READY;

	sequence status_a_read;
		reg_req_i.read && reg_req_i.addr == card_mon_pkg::OFF_SOCK_A_STATUS;
	endsequence

	sequence info_read;
		reg_req_i.read && reg_req_i.addr == card_mon_pkg::OFF_INFO;
	endsequence

	sync_two_stage_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // see [R17]
		$past(rst_n, 2) |-> pins_flat == $past({sock_b_pins_i, sock_a_pins_i}, 2))
		else $error("socket pins not delayed by two stages");

	detect_irq_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // see [R3]
		(events[card_mon_pkg::EV_DETECT] && enable_reg[card_mon_pkg::EV_DETECT])
		|=> irq_o && change_flags[card_mon_pkg::EV_DETECT])
		else $error("enabled card detect change gave no interrupt");

	status_change_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // see [R7]
		$changed(pins_sync[0].battery_first) |=> change_flags[card_mon_pkg::EV_BATTERY_FIRST])
		else $error("status change on socket a not flagged");

	flag_set_wins_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // see [R18]
		(events[B_READY] && clear_mask[B_READY])
		|=> change_flags[B_READY])
		else $error("clear beat a ready change");

	flag_sticky_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // see [R18]
		(change_flags[0] && !clear_mask[0]) [*3] |=> change_flags[0])
		else $error("change flag dropped without clear");

	irq_or_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // see [R18]
		$past(rst_n) && $stable(enable_reg) |-> irq_o == |(change_flags & enable_reg[NE-1:0]))
		else $error("interrupt not the or of enabled flags");

	wait_pass_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // see [R10]
		(sock_access_i[0] && !pins_sync[0].wait_req_n) |=> host_wait_req_n_oe_o && !host_wait_req_n_o)
		else $error("card wait not passed to host");

	wide_io_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // see [R19]
		(io_mode_reg[0] && sock_access_i[0] && !pins_sync[0].protect_or_wide)
		|=> host_wide_io_n_oe_o && !host_wide_io_n_o)
		else $error("wide i/o access not indicated");

	speaker_out_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // see [R9]
		(io_mode_reg[0] && !pins_sync[0].battery_second) |=> !card_audio_n_o)
		else $error("card audio not on speaker pin");

	status_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // see [R2]
		status_a_read |=> reg_rdata_o == $past(status_byte(pins_sync[0])))
		else $error("socket a status read wrong");

	busy_protect_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // see [R12]
		(info_read ##0 (!io_mode_reg[1] && !pins_sync[1].ready_busy && pins_sync[1].protect_or_wide))
		|=> reg_rdata_o[card_mon_pkg::INFO_BUSY + 1] && reg_rdata_o[card_mon_pkg::INFO_PROTECTED + 1])
		else $error("memory busy or protect not shown");

endmodule // card_socket_status_monitor

// ===== card_model.sv
`timescale 1ns/1ps
module card_model (
	// card behaviour
	input  wire logic                inserted_i,
	input  wire logic                access_i,
	input  wire logic                stretch_i,
	input  wire logic                ready_i,
	input  wire logic                battery_first_i,
	input  wire logic                battery_second_i,
	input  wire logic                protect_i,
	// socket pins
	output card_mon_pkg::sock_pins_s pins_o
);
	always_comb begin
		// empty socket: every pin rests on its pull-up
		pins_o = card_mon_pkg::sock_pins_s'(card_mon_pkg::PINS_IDLE);
		if (inserted_i) begin
			pins_o.detect_first = 1'b0;
			pins_o.detect_second = 1'b0;
			pins_o.battery_first = battery_first_i;
			pins_o.battery_second = battery_second_i;
			// a card only stretches a cycle it is taking part in
			pins_o.wait_req_n = !(stretch_i && access_i);
			pins_o.ready_busy = ready_i;
			pins_o.protect_or_wide = protect_i;
		end
	end
endmodule // card_model

// ===== tb_card_socket_status_monitor.sv
`timescale 1ns/1ps
module tb_card_socket_status_monitor;
	logic                     ref_clk_i;
	logic                     reset_n_i;
	card_mon_pkg::reg_req_s   req;
	logic [7:0]               rdata;
	card_mon_pkg::sock_pins_s pins_a;
	card_mon_pkg::sock_pins_s pins_b;
	logic [1:0]               acc, ins, stretch, rdy, bat1, bat2, prot;
	logic                     irq, wait_n, wait_oe, wide_n, wide_oe, audio_n, audio_oe;
	wire                      sel_pin;
	int                       miscompares;
	int                       num_checks;

	// shared speaker pin: pull-up unless the block drives it
	assign sel_pin = audio_oe ? audio_n : 1'b1;

	card_socket_status_monitor i_dut (
		.ref_clk_i           (ref_clk_i),
		.reset_n_i           (reset_n_i),
		.reg_req_i           (req),
		.reg_rdata_o         (rdata),
		.sock_a_pins_i       (pins_a),
		.sock_b_pins_i       (pins_b),
		.sock_access_i       (acc),
		.irq_o               (irq),
		.host_wait_req_n_o   (wait_n),
		.host_wait_req_n_oe_o(wait_oe),
		.host_wide_io_n_o    (wide_n),
		.host_wide_io_n_oe_o (wide_oe),
		.base_select_zero_i  (sel_pin),
		.card_audio_n_o      (audio_n),
		.card_audio_n_oe_o   (audio_oe)
	);

	card_model i_card_a (
		.inserted_i      (ins[0]),
		.access_i        (acc[0]),
		.stretch_i       (stretch[0]),
		.ready_i         (rdy[0]),
		.battery_first_i (bat1[0]),
		.battery_second_i(bat2[0]),
		.protect_i       (prot[0]),
		.pins_o          (pins_a)
	);

	card_model i_card_b (
		.inserted_i      (ins[1]),
		.access_i        (acc[1]),
		.stretch_i       (stretch[1]),
		.ready_i         (rdy[1]),
		.battery_first_i (bat1[1]),
		.battery_second_i(bat2[1]),
		.protect_i       (prot[1]),
		.pins_o          (pins_b)
	);

	// ***************************************************************
	// clock and helpers
	// ***************************************************************
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [3:0] addr, input logic [7:0] data);
		@(posedge ref_clk_i);
		req <= '{write: 1'b1, read: 1'b0, addr: addr, wdata: data};
		@(posedge ref_clk_i);
		req.write <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] addr, input logic [7:0] exp);
		@(posedge ref_clk_i);
		req <= '{write: 1'b0, read: 1'b1, addr: addr, wdata: 8'h00};
		@(posedge ref_clk_i);
		req.read <= 1'b0;
		// data stands only in the cycle after the read
		#1;
		chk(rdata, exp);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic give_verdict();
		if (miscompares == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ***************************************************************
	// watchdog
	// ***************************************************************
	initial begin
		// whole sequence needs well under a thousand cycles
		repeat (20000) @(posedge ref_clk_i);
		miscompares++;
		give_verdict();
	end

	// ***************************************************************
	// tests
	// ***************************************************************
	initial begin
		miscompares = 0;
		num_checks = 0;
		reset_n_i = 1'b0;
		req = '0;
		{acc, ins, stretch, prot} = '0;
		{rdy, bat1, bat2, prot} = {2'h3, 2'h3, 2'h3, 2'h3};
		repeat (20) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		settle(5);
		reg_rd(card_mon_pkg::OFF_MODE, 8'h00);
		reg_rd(card_mon_pkg::OFF_CHANGE_ENABLE, 8'h00);
		reg_rd(card_mon_pkg::OFF_CHANGE_STATUS, 8'h00);
		reg_rd(4'h7, 8'h00);
		reg_rd(card_mon_pkg::OFF_SOCK_A_STATUS, 8'hfb);
		reg_rd(card_mon_pkg::OFF_INFO, 8'h07);
		chk({7'h0, audio_oe}, 8'h01);
		reg_wr(card_mon_pkg::OFF_MODE, 8'hff);
		reg_rd(card_mon_pkg::OFF_MODE, 8'h03);
		reg_wr(card_mon_pkg::OFF_MODE, 8'h00);
		reg_wr(card_mon_pkg::OFF_CHANGE_ENABLE, 8'h01);
		reg_rd(card_mon_pkg::OFF_CHANGE_ENABLE, 8'h01);
		// insertion of socket a, enabled
		@(posedge ref_clk_i);
		ins[0] <= 1'b1;
		settle(6);
		chk({7'h0, irq}, 8'h01);
		reg_rd(card_mon_pkg::OFF_SOCK_A_STATUS, 8'hfc);
		reg_rd(card_mon_pkg::OFF_CHANGE_STATUS, 8'h01);
		reg_wr(card_mon_pkg::OFF_CHANGE_CLEAR, 8'h01);
		settle(2);
		chk({7'h0, irq}, 8'h00);
		reg_rd(card_mon_pkg::OFF_CHANGE_STATUS, 8'h00);
		// insertion of socket b, masked until enabled
		@(posedge ref_clk_i);
		ins[1] <= 1'b1;
		settle(6);
		chk({7'h0, irq}, 8'h00);
		reg_rd(card_mon_pkg::OFF_CHANGE_STATUS, 8'h10);
		reg_rd(card_mon_pkg::OFF_SOCK_B_STATUS, 8'hfc);
		reg_wr(card_mon_pkg::OFF_CHANGE_ENABLE, 8'hff);
		settle(2);
		chk({7'h0, irq}, 8'h01);
		reg_wr(card_mon_pkg::OFF_CHANGE_CLEAR, 8'hff);
		// battery levels in memory mode
		@(posedge ref_clk_i);
		bat1[0] <= 1'b0;
		bat2[0] <= 1'b0;
		settle(6);
		chk({7'h0, irq}, 8'h01);
		reg_rd(card_mon_pkg::OFF_SOCK_A_STATUS, 8'he4);
		reg_rd(card_mon_pkg::OFF_CHANGE_STATUS, 8'h06);
		reg_wr(card_mon_pkg::OFF_CHANGE_CLEAR, 8'hff);
		// i/o mode: status change counts, audio does not
		reg_wr(card_mon_pkg::OFF_MODE, 8'h01);
		@(posedge ref_clk_i);
		bat1[0] <= 1'b1;
		bat2[0] <= 1'b1;
		settle(6);
		reg_rd(card_mon_pkg::OFF_CHANGE_STATUS, 8'h02);
		chk({7'h0, audio_n}, 8'h01);
		@(posedge ref_clk_i);
		bat2[0] <= 1'b0;
		settle(6);
		chk({7'h0, audio_n}, 8'h00);
		reg_rd(card_mon_pkg::OFF_CHANGE_STATUS, 8'h02);
		reg_wr(card_mon_pkg::OFF_CHANGE_CLEAR, 8'hff);
		// wide i/o request and wait stretch on socket a
		@(posedge ref_clk_i);
		prot[0] <= 1'b0;
		settle(6);
		reg_rd(card_mon_pkg::OFF_INFO, 8'h0d);
		chk({7'h0, wide_oe}, 8'h00);
		@(posedge ref_clk_i);
		acc[0] <= 1'b1;
		stretch[0] <= 1'b1;
		settle(5);
		chk({6'h0, wide_oe, wide_n}, 8'h02);
		chk({6'h0, wait_oe, wait_n}, 8'h02);
		@(posedge ref_clk_i);
		stretch[0] <= 1'b0;
		settle(5);
		chk({6'h0, wait_oe, wait_n}, 8'h00);
		@(posedge ref_clk_i);
		acc[0] <= 1'b0;
		settle(5);
		chk({7'h0, wide_oe}, 8'h00);
		// busy then ready on socket b
		@(posedge ref_clk_i);
		rdy[1] <= 1'b0;
		settle(6);
		reg_rd(card_mon_pkg::OFF_SOCK_B_STATUS, 8'hdc);
		reg_rd(card_mon_pkg::OFF_CHANGE_STATUS, 8'h80);
		reg_rd(card_mon_pkg::OFF_INFO, 8'h4d);
		@(posedge ref_clk_i);
		rdy[1] <= 1'b1;
		// the clear lands on the very edge that sets the ready flag again
		@(posedge ref_clk_i);
		reg_wr(card_mon_pkg::OFF_CHANGE_CLEAR, 8'hff);
		reg_rd(card_mon_pkg::OFF_CHANGE_STATUS, 8'h80);
		reg_rd(card_mon_pkg::OFF_INFO, 8'h0d);
		reg_rd(card_mon_pkg::OFF_SOCK_B_STATUS, 8'hfc);
		// removal of socket a in i/o mode
		reg_wr(card_mon_pkg::OFF_CHANGE_CLEAR, 8'hff);
		@(posedge ref_clk_i);
		ins[0] <= 1'b0;
		settle(6);
		reg_rd(card_mon_pkg::OFF_CHANGE_STATUS, 8'h01);
		chk({7'h0, irq}, 8'h01);
		give_verdict();
	end
endmodule // tb_card_socket_status_monitor
